// >>> acc_defs.vh
`ifndef ACC_DEFS_VH
`define ACC_DEFS_VH
`define ACC_ADDR_CAL_CTRL 8'hF5
`define ACC_RESET_VALUE 8'h00
`define ACC_BIT_BUSY 7
`define ACC_BIT_GAIN_DIS 6
`define ACC_BIT_AVG_HI 5
`define ACC_BIT_AVG_LO 4
`define ACC_BIT_OFFS_DIS 3
`define ACC_BIT_MODE 2
`define ACC_BIT_TYPE 1
`define ACC_BIT_START 0
`define ACC_AVG_CODE0 7'h0f
`define ACC_AVG_CODE1 7'h1f
`define ACC_AVG_CODE2 7'h2f
`define ACC_AVG_CODE3 7'h3f
`define ACC_STEPS 4'hc
`define ACC_CONV_CYCLES 5'h10
`define ACC_COEFF_W 12
`endif

// >>> acc_avg_step.v
`timescale 1ns/1ps
`default_nettype none
`include "acc_defs.vh"
// one bit decision: averages a set number of comparator readings
module acc_avg_step (
  input wire clk,
  input wire resetn,
  input wire start,
  input wire [6:0] count,
  input wire cmp_in,
  output reg done,
  output reg decision
);
  reg [6:0] left;
  reg [6:0] ones;
  reg run;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      left <= 7'h00;
      ones <= 7'h00;
      run <= 1'b0;
      done <= 1'b0;
      decision <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        left <= count;
        ones <= 7'h00;
        run <= 1'b1;
      end else if (run) begin
        ones <= ones + {6'h00, cmp_in};
        left <= left - 7'd1;
        if (left == 7'd1) begin
          run <= 1'b0;
          done <= 1'b1;
          // majority of readings
          decision <= ({ones + {6'h00, cmp_in}, 1'b0} > {1'b0, count});
        end
      end
    end
  end
endmodule // acc_avg_step
`default_nettype wire

// >>> acc_cal_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "acc_defs.vh"
module acc_cal_ctrl (
  input wire clk,
  input wire resetn,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata,
  input wire conv_start,
  input wire cmp_in,
  output reg [11:0] dac_code,
  output reg [11:0] offset_coeff,
  output reg [11:0] gain_coeff,
  output reg offset_apply,
  output reg gain_apply,
  output reg cal_mode,
  output reg busy
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_CONV = 4'b0010;
  localparam ST_STEP = 4'b0100;
  localparam ST_WAIT = 4'b1000;
  reg [3:0] state;
  reg gain_dis;
  reg [1:0] avg_sel;
  reg offs_dis;
  reg mode_sel;
  reg type_sel;
  reg start_bit;
  reg cal_type;
  reg [4:0] conv_cnt;
  reg [3:0] bit_idx;
  reg [11:0] sar;
  reg step_go;
  reg [6:0] avg_count;
  wire step_done;
  wire step_dec;
  wire sel = (sfr_addr == `ACC_ADDR_CAL_CTRL);
  wire wr = sel & sfr_wr;
  wire [7:0] reg_value = {busy, gain_dis, avg_sel, offs_dis, mode_sel, type_sel, start_bit};
  wire [11:0] trial = sar | (12'h800 >> bit_idx);
  //////////////////////////////////////////////////////////////////////
  // averaging count decode
  always @* begin
    case (avg_sel)
      2'b00: avg_count = `ACC_AVG_CODE0;
      2'b01: avg_count = `ACC_AVG_CODE1;
      2'b10: avg_count = `ACC_AVG_CODE2;
      2'b11: avg_count = `ACC_AVG_CODE3;
      default: avg_count = `ACC_AVG_CODE0;
    endcase
  end
  acc_avg_step u_step (
    .clk(clk),
    .resetn(resetn),
    .start(step_go),
    .count(avg_count),
    .cmp_in(cmp_in),
    .done(step_done),
    .decision(step_dec)
  );
  //////////////////////////////////////////////////////////////////////
  // decode of the sequencer state
  wire trial_phase = (state == ST_STEP) || (state == ST_WAIT);
  wire start_req = wr && sfr_wdata[`ACC_BIT_START];
  wire last_step = (bit_idx == `ACC_STEPS - 4'h1);
  wire step_end = (state == ST_WAIT) && step_done;
  wire cal_end = step_end && last_step;
  wire [11:0] result = step_dec ? trial : sar;
  //////////////////////////////////////////////////////////////////////
  // next state, a start write wins over a conversion request
  reg [3:0] next_state;
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_req) begin
          next_state = ST_STEP;
        end else if (conv_start) begin
          next_state = ST_CONV;
        end
      end
      ST_CONV: begin
        if (conv_cnt == 5'h01) begin
          next_state = ST_IDLE;
        end
      end
      ST_STEP: begin
        next_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (cal_end) begin
          next_state = ST_IDLE;
        end else if (step_done) begin
          next_state = ST_STEP;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end
  //////////////////////////////////////////////////////////////////////
  // state register
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // busy flag, start bit and latched calibration type
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'b0;
      start_bit <= 1'b0;
      cal_type <= 1'b0;
    end else if (state == ST_IDLE) begin
      if (start_req) begin
        start_bit <= 1'b1;
        cal_type <= sfr_wdata[`ACC_BIT_TYPE];
        busy <= 1'b1;
      end else if (conv_start) begin
        busy <= 1'b1;
      end
    end else if (state == ST_CONV) begin
      if (conv_cnt == 5'h01) begin
        busy <= 1'b0;
      end
    end else if (cal_end) begin
      start_bit <= 1'b0;
      busy <= 1'b0;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // conversion timer and successive approximation register
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      conv_cnt <= 5'h00;
      bit_idx <= 4'h0;
      sar <= 12'h000;
      step_go <= 1'b0;
    end else begin
      step_go <= (state == ST_STEP);
      if (state == ST_CONV) begin
        conv_cnt <= conv_cnt - 5'h01;
      end else if (state == ST_IDLE && !start_req && conv_start) begin
        conv_cnt <= `ACC_CONV_CYCLES;
      end
      if (state == ST_IDLE && start_req) begin
        sar <= 12'h000;
        bit_idx <= 4'h0;
      end else if (step_end) begin
        if (step_dec) begin
          sar <= trial;
        end
        if (!last_step) begin
          bit_idx <= bit_idx + 4'h1;
        end
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  // read data capture
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sfr_rdata <= `ACC_RESET_VALUE;
    end else if (sel && sfr_rd) begin
      sfr_rdata <= reg_value;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // writable fields, bit 7 and bit 0 are kept by the sequencer
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gain_dis <= 1'b0;
      avg_sel <= 2'b00;
      offs_dis <= 1'b0;
      mode_sel <= 1'b0;
      type_sel <= 1'b0;
    end else if (wr) begin
      gain_dis <= sfr_wdata[`ACC_BIT_GAIN_DIS];
      avg_sel <= sfr_wdata[`ACC_BIT_AVG_HI:`ACC_BIT_AVG_LO];
      offs_dis <= sfr_wdata[`ACC_BIT_OFFS_DIS];
      mode_sel <= sfr_wdata[`ACC_BIT_MODE];
      type_sel <= sfr_wdata[`ACC_BIT_TYPE];
    end
  end
  //////////////////////////////////////////////////////////////////////
  // registered copies for the converter datapath
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gain_apply <= 1'b0;
      offset_apply <= 1'b0;
      cal_mode <= 1'b0;
      dac_code <= 12'h000;
    end else begin
      gain_apply <= ~gain_dis;
      offset_apply <= ~offs_dis;
      cal_mode <= mode_sel;
      dac_code <= trial_phase ? trial : sar;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // coefficient storage, only the calibrated one is replaced
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      offset_coeff <= 12'h000;
      gain_coeff <= 12'h000;
    end else if (cal_end) begin
      if (cal_type) begin
        gain_coeff <= result;
      end else begin
        offset_coeff <= result;
      end
    end
  end
endmodule // acc_cal_ctrl
`default_nettype wire

// >>> acc_cal_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module acc_cal_ctrl_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic conv_start,
  input wire logic [11:0] offset_coeff,
  input wire logic [11:0] gain_coeff,
  input wire logic offset_apply,
  input wire logic gain_apply,
  input wire logic busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire wf = sfr_wr && sfr_addr == 8'hf5;
  // calibration type taken by the last accepted start
  logic kind;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      kind <= 1'b0;
    end else if (wf && sfr_wdata[0] && !busy) begin
      kind <= sfr_wdata[1];
    end
  end
  sequence quiet_wr;
    wf ##1 !sfr_wr ##1 1;
  endsequence
  sequence conv_go;
    conv_start && !busy && !sfr_wr;
  endsequence
  conv_len_a: assert property (conv_go |=> busy [*8] ##1 busy [*8] ##1 !busy) else $error("conv length");
  cal_go_a: assert property (wf && sfr_wdata[0] && !busy |=> busy) else $error("cal not started");
  busy_ro_a: assert property (wf && sfr_wdata[7] && !sfr_wdata[0] && !busy && !conv_start |=> !busy) else $error("busy set");
  gain_app_a: assert property (quiet_wr |-> gain_apply == !$past(sfr_wdata[6], 2)) else $error("gain apply");
  offs_app_a: assert property (quiet_wr |-> offset_apply == !$past(sfr_wdata[3], 2)) else $error("offs apply");
  gain_keep_a: assert property (!$stable(gain_coeff) |-> $fell(busy) && kind) else $error("gain changed");
  offs_keep_a: assert property (!$stable(offset_coeff) |-> $fell(busy) && !kind) else $error("offs changed");
  rst_zero_a: assert property ($rose(resetn) |-> !busy && gain_coeff == 12'h000 && offset_coeff == 12'h000)
    else $error("reset");
  busy_read_a: assert property (sfr_rd && sfr_addr == 8'hf5 |=> sfr_rdata[7] == $past(busy)) else $error("busy readback");
endmodule // acc_cal_ctrl_chk
bind acc_cal_ctrl acc_cal_ctrl_chk i_chk (.clk, .resetn, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
  .conv_start, .offset_coeff, .gain_coeff, .offset_apply, .gain_apply, .busy);
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 0, resetn = 0, sfr_wr = 0, sfr_rd = 0, conv_start = 0, cmp_in = 0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic [11:0] offset_coeff, gain_coeff, dac_code;
  logic offset_apply, gain_apply, cal_mode, busy;
  int num_errors = 0, checks = 0, cyc = 0, n, l0;
  always #5 clk = ~clk;
  acc_cal_ctrl i_dut (.clk, .resetn, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .conv_start, .cmp_in,
    .dac_code, .offset_coeff, .gain_coeff, .offset_apply, .gain_apply, .cal_mode, .busy);
  ////////////////////////////////////////////////////////////
  task chk(input logic [11:0] s, e, input string w);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", w, e, s);
    end
  endtask
  task wr(input logic [7:0] a, v);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= v;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] e);
    @(posedge clk);
    sfr_addr <= 8'hf5;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1 chk(sfr_rdata, e, "reg");
  endtask
  // counts cycles until busy drops
  task run(output int c);
    c = 0;
    do begin
      @(posedge clk);
      #1 c++;
    end while (busy === 1'b1 && c < 2000);
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      num_errors++;
      report_and_stop;
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    rd(8'h00);
    wr(8'hf5, 8'hc8);
    wr(8'hf4, 8'h37);
    rd(8'h48);
    chk(gain_apply, 1'b0, "gain");
    chk(offset_apply, 1'b0, "offs");
    wr(8'hf5, 8'h04);
    rd(8'h04);
    chk(gain_apply, 1'b1, "gain");
    chk(offset_apply, 1'b1, "offs");
    chk(cal_mode, 1'b1, "mode");
    @(posedge clk);
    conv_start <= 1'b1;
    @(posedge clk);
    conv_start <= 1'b0;
    run(n);
    chk(n, 12'h010, "conv");
    @(posedge clk);
    conv_start <= 1'b1;
    @(posedge clk);
    conv_start <= 1'b0;
    rd(8'h84);
    // start write while converting is refused, busy still ends after 16 cycles
    wr(8'hf5, 8'h05);
    run(n);
    chk(n, 12'h00c, "conv busy");
    rd(8'h04);
    for (int k = 0; k < 4; k++) begin
      cmp_in <= k < 2;
      wr(8'hf5, {2'b00, k[1:0], 1'b0, 1'b1, k[0], 1'b1});
      run(n);
      if (k == 0) l0 = n;
      chk(n - l0, 192 * k, "length");
      rd({2'b00, k[1:0], 1'b0, 1'b1, k[0], 1'b0});
      chk(offset_coeff, k < 2 ? 12'hfff : 12'h000, "offs coeff");
      chk(gain_coeff, k == 1 || k == 2 ? 12'hfff : 12'h000, "gain coeff");
      chk(dac_code, k < 2 ? 12'hfff : 12'h000, "dac");
    end
    report_and_stop;
  end
endmodule // tb
`default_nettype wire
